//--- logic/sfr_read_rewind.sv
/*
 Read side of the sector buffer: current and confirmed read indices with
 rewind, the receive path of a UDMA read through a word FIFO, the extra
 word tally, the overrun flag and the running CRC.
 Assumes the buffer manager, the transfer engine and the microcontroller
 register strobes all run on clk_in; only resetn_in is asynchronous.
*/
module sfr_read_rewind
    import sfr_pkg::*;
(
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    // Register reads
    input  wire logic [sfr_pkg::ADDR_WIDTH-1:0] reg_addr_in,
    input  wire logic                          reg_read_in,
    output logic      [7:0]                    reg_read_data_out,
    // Control strobes from drive_port_config_one
    input  wire logic                          launch_transfer_bit_in,
    input  wire logic                          soft_reset_bit_in,
    // Buffer manager side
    input  wire logic                          usb_fetch_in,
    input  wire logic                          usb_ack_in,
    input  wire logic                          usb_ack_timeout_in,
    input  wire logic                          usb_resend_in,
    // Drive side fetches
    input  wire logic                          ata_fetch_in,
    output logic      [sfr_pkg::INDEX_WIDTH-1:0] fifo_read_index_out,
    output logic      [sfr_pkg::INDEX_WIDTH-1:0] confirmed_read_index_out,
    // UDMA read receive path
    input  wire logic                          udma_start_in,
    input  wire logic                          udma_expected_done_in,
    input  wire logic                          udma_end_in,
    input  wire logic                          udma_word_valid_in,
    output logic                               udma_word_ready_out,
    input  wire logic [sfr_pkg::WORD_WIDTH-1:0] udma_word_in,
    output logic                               sector_word_valid_out,
    input  wire logic                          sector_word_ready_in,
    output logic      [sfr_pkg::WORD_WIDTH-1:0] sector_word_out,
    output logic                               udma_overrun_flag_out,
    output logic      [sfr_pkg::TALLY_WIDTH-1:0] extra_word_tally_out,
    output logic      [sfr_pkg::WORD_WIDTH-1:0] udma_crc_out
);
    import sfr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [INDEX_WIDTH-1:0] step_index(
        input logic [INDEX_WIDTH-1:0] value
    );
        step_index = value + INDEX_STEP;
    endfunction

    function automatic logic [7:0] high_byte(
        input logic [INDEX_WIDTH-1:0] value
    );
        high_byte = {2'h0, value[INDEX_WIDTH-1:8]};
    endfunction

    function automatic logic [WORD_WIDTH-1:0] crc_word(
        input logic [WORD_WIDTH-1:0] crc,
        input logic [WORD_WIDTH-1:0] data
    );
        logic [WORD_WIDTH-1:0] acc;
        logic                  fb;
        acc = crc;
        for (int i = WORD_WIDTH - 1; i >= 0; i--) begin
            fb  = acc[WORD_WIDTH-1] ^ data[i];
            acc = {acc[WORD_WIDTH-2:0], 1'b0};
            if (fb) begin
                acc = acc ^ CRC_POLY;
            end
        end
        crc_word = acc;
    endfunction

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] reset_sync;
    logic       resetn;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reset_sync <= SYNC_RESET;
        end else begin
            reset_sync <= {reset_sync[0], 1'b1};
        end
    end

    assign resetn = reset_sync[1];

    // ------------------------------------------------------------
    // Read index and confirmed backup
    // ------------------------------------------------------------
    logic [INDEX_WIDTH-1:0] fifo_read_index;
    logic [INDEX_WIDTH-1:0] confirmed_read_index;
    logic [INDEX_WIDTH-1:0] next_fifo_read_index;
    logic [INDEX_WIDTH-1:0] next_confirmed_read_index;
    logic                   rewind;

    // Rewind only ever serves the buffer manager
    assign rewind = usb_ack_timeout_in || usb_resend_in;

    always_comb begin
        next_fifo_read_index      = fifo_read_index;
        next_confirmed_read_index = confirmed_read_index;
        if (ata_fetch_in) begin
            // Drive fetch commits at once, so a later rewind cannot undo it
            next_fifo_read_index      = step_index(fifo_read_index);
            next_confirmed_read_index = step_index(fifo_read_index);
        end else if (rewind) begin
            next_fifo_read_index = confirmed_read_index;
        end else begin
            if (usb_fetch_in) begin
                next_fifo_read_index = step_index(fifo_read_index);
            end
            if (usb_ack_in) begin
                next_confirmed_read_index = next_fifo_read_index;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            fifo_read_index      <= INDEX_RESET;
            confirmed_read_index <= INDEX_RESET;
        end else begin
            fifo_read_index      <= next_fifo_read_index;
            confirmed_read_index <= next_confirmed_read_index;
        end
    end

    assign fifo_read_index_out      = fifo_read_index;
    assign confirmed_read_index_out = confirmed_read_index;

    // ------------------------------------------------------------
    // UDMA receive state
    // ------------------------------------------------------------
    sfr_rx_state_type rx_state;
    sfr_rx_state_type next_rx_state;
    logic             clear_tally;
    logic             word_taken;
    logic             word_extra;
    logic             fifo_ready;

    assign clear_tally = launch_transfer_bit_in || soft_reset_bit_in;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            SFR_IDLE: begin
                if (udma_start_in) begin
                    next_rx_state = SFR_XFER;
                end
            end
            SFR_XFER: begin
                if (udma_end_in) begin
                    next_rx_state = SFR_IDLE;
                end else if (udma_expected_done_in) begin
                    next_rx_state = SFR_PAUSED;
                end
            end
            SFR_PAUSED: begin
                if (udma_end_in) begin
                    next_rx_state = SFR_IDLE;
                end
            end
            default: begin
                next_rx_state = SFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            rx_state <= SFR_IDLE;
        end else if (soft_reset_bit_in) begin
            rx_state <= SFR_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // Extra words are always accepted so the drive can finish its burst
    assign udma_word_ready_out = (rx_state == SFR_PAUSED) ? 1'b1 : fifo_ready;
    assign word_taken = udma_word_valid_in && udma_word_ready_out
                        && (rx_state != SFR_IDLE);
    assign word_extra = word_taken && (rx_state == SFR_PAUSED);

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    sfr_fifo #(
        .WIDTH (WORD_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in         (clk_in),
        .resetn_in      (resetn),
        .push_valid_in  (udma_word_valid_in && (rx_state == SFR_XFER)),
        .push_ready_out (fifo_ready),
        .push_data_in   (udma_word_in),
        .pop_valid_out  (sector_word_valid_out),
        .pop_ready_in   (sector_word_ready_in),
        .pop_data_out   (sector_word_out)
    );

    // ------------------------------------------------------------
    // Extra word tally
    // ------------------------------------------------------------
    logic [TALLY_WIDTH-1:0] extra_word_tally;

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            extra_word_tally <= TALLY_RESET;
        end else if (clear_tally) begin
            extra_word_tally <= TALLY_RESET;
        end else if (word_extra && extra_word_tally != TALLY_LIMIT) begin
            extra_word_tally <= extra_word_tally + TALLY_STEP;
        end
    end

    assign extra_word_tally_out = extra_word_tally;

    // ------------------------------------------------------------
    // Overrun flag
    // ------------------------------------------------------------
    logic udma_overrun_flag;

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            udma_overrun_flag <= 1'b0;
        end else if (word_extra) begin
            udma_overrun_flag <= 1'b1;
        end else if (clear_tally) begin
            udma_overrun_flag <= 1'b0;
        end
    end

    assign udma_overrun_flag_out = udma_overrun_flag;

    // ------------------------------------------------------------
    // Running CRC over every received word
    // ------------------------------------------------------------
    logic [WORD_WIDTH-1:0] udma_crc;

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            udma_crc <= CRC_SEED;
        end else if (udma_start_in && rx_state == SFR_IDLE) begin
            udma_crc <= CRC_SEED;
        end else if (word_taken) begin
            udma_crc <= crc_word(udma_crc, udma_word_in);
        end
    end

    assign udma_crc_out = udma_crc;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] reg_read_data;
    logic [7:0] next_reg_read_data;

    always_comb begin
        case (reg_addr_in)
            READ_INDEX_LOW_OFFSET: begin
                next_reg_read_data = fifo_read_index[7:0];
            end
            READ_INDEX_HIGH_OFFSET: begin
                next_reg_read_data = high_byte(fifo_read_index);
            end
            CONFIRMED_READ_INDEX_LOW_OFFSET: begin
                next_reg_read_data = confirmed_read_index[7:0];
            end
            CONFIRMED_READ_INDEX_HIGH_OFFSET: begin
                next_reg_read_data = high_byte(confirmed_read_index);
            end
            UDMA_EXTRA_WORD_TALLY_OFFSET: begin
                next_reg_read_data = {4'h0, extra_word_tally};
            end
            default: begin
                next_reg_read_data = READ_DATA_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn) begin
        if (!resetn) begin
            reg_read_data <= READ_DATA_RESET;
        end else if (reg_read_in) begin
            reg_read_data <= next_reg_read_data;
        end
    end

    assign reg_read_data_out = reg_read_data;

endmodule // sfr_read_rewind

//--- logic/sfr_pkg.sv
/*
 Package for the sector buffer read side: register offsets, field widths,
 reset values, CRC constants and transfer states.
 Assumes one core clock and byte-wide register reads by the microcontroller.
*/
package sfr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int INDEX_WIDTH   = 14;
    localparam int HIGH_WIDTH    = 6;
    localparam int TALLY_WIDTH   = 4;
    localparam int WORD_WIDTH    = 16;
    localparam int ADDR_WIDTH    = 16;
    localparam int FIFO_DEPTH    = 32;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] READ_INDEX_LOW_OFFSET            = 16'hF0EF;
    localparam logic [15:0] READ_INDEX_HIGH_OFFSET           = 16'hF0F0;
    localparam logic [15:0] CONFIRMED_READ_INDEX_LOW_OFFSET  = 16'hF0F1;
    localparam logic [15:0] CONFIRMED_READ_INDEX_HIGH_OFFSET = 16'hF0F2;
    localparam logic [15:0] UDMA_EXTRA_WORD_TALLY_OFFSET     = 16'hF0F9;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [13:0] INDEX_RESET   = 14'h0000;
    localparam logic [13:0] INDEX_STEP    = 14'h0001;
    localparam logic [3:0]  TALLY_RESET   = 4'h0;
    localparam logic [3:0]  TALLY_LIMIT   = 4'hF;
    localparam logic [3:0]  TALLY_STEP    = 4'h1;
    localparam logic [7:0]  READ_DATA_RESET = 8'h00;
    localparam logic [15:0] CRC_SEED      = 16'h4ABA;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [1:0]  SYNC_RESET    = 2'h0;

    // ------------------------------------------------------------
    // Receive states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFR_IDLE   = 3'h1,
        SFR_XFER   = 3'h2,
        SFR_PAUSED = 3'h4
    } sfr_rx_state_type;

endpackage

//--- logic/sfr_fifo.sv
/*
 Word FIFO with parameters for width and depth, valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset already synchronised.
*/
module sfr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             push_valid_in,
    output logic                  push_ready_out,
    input  wire logic [WIDTH-1:0] push_data_in,
    output logic                  pop_valid_out,
    input  wire logic             pop_ready_in,
    output logic      [WIDTH-1:0] pop_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    write_slot;
    logic [PW-1:0]    read_slot;
    logic [PW:0]      fill;
    logic             do_push;
    logic             do_pop;

    assign push_ready_out = (fill != (PW+1)'(DEPTH));
    assign pop_valid_out  = (fill != '0);
    assign do_push        = push_valid_in && push_ready_out;
    assign do_pop         = pop_valid_out && pop_ready_in;
    assign pop_data_out   = store[read_slot];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (do_push) begin
            store[write_slot] <= push_data_in;
        end
    end

    // ------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            write_slot <= '0;
            read_slot  <= '0;
            fill       <= '0;
        end else begin
            if (do_push) begin
                write_slot <= write_slot + 1'b1;
            end
            if (do_pop) begin
                read_slot <= read_slot + 1'b1;
            end
            if (do_push && !do_pop) begin
                fill <= fill + 1'b1;
            end else if (do_pop && !do_push) begin
                fill <= fill - 1'b1;
            end
        end
    end

endmodule // sfr_fifo

//--- tb/sfr_read_rewind_properties.sv
/*
 Checker for the sector buffer read side, bound to sfr_read_rewind.
 Assumes one clock domain and the active-low reset port.
*/
module sfr_read_rewind_properties
    import sfr_pkg::*;
(
    input wire logic                   clk_in,
    input wire logic                   resetn_in,
    input wire logic [ADDR_WIDTH-1:0]  reg_addr_in,
    input wire logic                   reg_read_in,
    input wire logic [7:0]             reg_read_data_out,
    input wire logic                   launch_transfer_bit_in,
    input wire logic                   soft_reset_bit_in,
    input wire logic                   usb_ack_in,
    input wire logic                   usb_ack_timeout_in,
    input wire logic                   usb_resend_in,
    input wire logic                   ata_fetch_in,
    input wire logic [INDEX_WIDTH-1:0] fifo_read_index_out,
    input wire logic [INDEX_WIDTH-1:0] confirmed_read_index_out,
    input wire logic                   udma_overrun_flag_out,
    input wire logic [TALLY_WIDTH-1:0] extra_word_tally_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    AST_READ_LOW: assert property (reg_read_in && reg_addr_in == READ_INDEX_LOW_OFFSET
        |=> reg_read_data_out == $past(fifo_read_index_out[7:0])) else $error("low byte");
    AST_READ_BK_HIGH: assert property (reg_read_in
        && reg_addr_in == CONFIRMED_READ_INDEX_HIGH_OFFSET
        |=> reg_read_data_out == {2'b00, $past(confirmed_read_index_out[13:8])})
        else $error("backup high byte");
    AST_ATA_STEP: assert property (ata_fetch_in |=>
        fifo_read_index_out == $past(fifo_read_index_out) + INDEX_STEP
        && confirmed_read_index_out == fifo_read_index_out) else $error("drive fetch");
    AST_TIMEOUT: assert property (usb_ack_timeout_in && !ata_fetch_in |=>
        fifo_read_index_out == $past(confirmed_read_index_out)) else $error("timeout rewind");
    AST_RESEND: assert property (usb_resend_in && !ata_fetch_in |=>
        fifo_read_index_out == $past(confirmed_read_index_out)) else $error("resend rewind");
    AST_ACK: assert property (usb_ack_in && !ata_fetch_in && !usb_ack_timeout_in
        && !usb_resend_in |=> confirmed_read_index_out == fifo_read_index_out)
        else $error("ack commit");
    AST_BK_HOLD: assert property (!ata_fetch_in && !usb_ack_in |=>
        $stable(confirmed_read_index_out)) else $error("backup moved");
    AST_TALLY_CLEAR: assert property (launch_transfer_bit_in || soft_reset_bit_in |=>
        extra_word_tally_out == TALLY_RESET) else $error("tally not cleared");
    AST_TALLY_SAT: assert property (extra_word_tally_out == TALLY_LIMIT
        && !launch_transfer_bit_in && !soft_reset_bit_in
        |=> extra_word_tally_out == TALLY_LIMIT) else $error("tally wrapped");
    AST_TALLY_STEP: assert property (!launch_transfer_bit_in && !soft_reset_bit_in |=>
        extra_word_tally_out == $past(extra_word_tally_out)
        || extra_word_tally_out == $past(extra_word_tally_out) + TALLY_STEP)
        else $error("tally jump");
    AST_FLAG: assert property (extra_word_tally_out != TALLY_RESET |->
        udma_overrun_flag_out) else $error("overrun flag");
endmodule // sfr_read_rewind_properties

bind sfr_read_rewind sfr_read_rewind_properties u_props (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_read_in(reg_read_in), .reg_read_data_out(reg_read_data_out),
    .launch_transfer_bit_in(launch_transfer_bit_in), .soft_reset_bit_in(soft_reset_bit_in),
    .usb_ack_in(usb_ack_in), .usb_ack_timeout_in(usb_ack_timeout_in),
    .usb_resend_in(usb_resend_in), .ata_fetch_in(ata_fetch_in),
    .fifo_read_index_out(fifo_read_index_out),
    .confirmed_read_index_out(confirmed_read_index_out),
    .udma_overrun_flag_out(udma_overrun_flag_out), .extra_word_tally_out(extra_word_tally_out)
);

//--- tb/sfr_drive_model.sv
/*
 Drive-side transfer engine and sector-side sink.
 Assumes the same clock as the block; the sink stalls until drained.
*/
module sfr_drive_model
(
    input  wire logic        clk_in,
    input  wire logic        drain_in,
    output logic             word_valid_out,
    input  wire logic        word_ready_in,
    output logic [15:0]      word_out,
    input  wire logic        sector_valid_in,
    output logic             sector_ready_out,
    input  wire logic [15:0] sector_word_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] got[$];
    initial begin
        word_valid_out = 1'b0;
        word_out = 16'hFFFF;
        sector_ready_out = 1'b0;
    end
    // Sink takes a word at each accepted edge
    always @(posedge clk_in) begin
        if (sector_valid_in && sector_ready_out) begin
            got.push_back(sector_word_in);
        end
        #1;
        sector_ready_out = drain_in;
    end
    // Word held until the edge that sees ready
    task automatic send(input logic [15:0] w);
        logic r;
        int n;
        word_out = w;
        word_valid_out = 1'b1;
        r = 1'b0;
        n = 0;
        while (!r && n < 100) begin
            @(negedge clk_in);
            r = word_ready_in;
            @(posedge clk_in);
            n++;
        end
        #1;
    endtask
    // Released bus shows inverted data
    task automatic release_bus();
        word_valid_out = 1'b0;
        word_out = ~word_out;
    endtask
endmodule // sfr_drive_model

//--- tb/sfr_read_rewind_test.sv
/*
 Self-checking bench for sfr_read_rewind.
 Assumes the checker is bound and the drive model sits on the UDMA path.
*/
module sfr_read_rewind_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sfr_pkg::*;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic        reg_read = 1'b0;
    logic [9:0]  ev = 10'h000;
    logic        drain = 1'b0;
    logic [13:0] ci = 14'h0000;
    logic [13:0] cb = 14'h0000;
    logic [15:0] ecrc;
    int          n_fail = 0;
    int          checked = 0;
    wire logic [7:0]  rdata;
    wire logic [13:0] idx, bk;
    wire logic        wvalid, wready, svalid, sready, flag;
    wire logic [15:0] wdata, sdata, crc;
    wire logic [3:0]  tally;
    localparam logic [9:0] LAUNCH = 10'h200, SOFT = 10'h100, FETCH = 10'h080, ACK = 10'h040;
    localparam logic [9:0] TMO = 10'h020, RESEND = 10'h010, ATA = 10'h008, START = 10'h004;
    localparam logic [9:0] DONE = 10'h002, FINISH = 10'h001;

    sfr_read_rewind DUT (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
        .reg_read_in(reg_read), .reg_read_data_out(rdata), .launch_transfer_bit_in(ev[9]),
        .soft_reset_bit_in(ev[8]), .usb_fetch_in(ev[7]), .usb_ack_in(ev[6]),
        .usb_ack_timeout_in(ev[5]), .usb_resend_in(ev[4]), .ata_fetch_in(ev[3]),
        .fifo_read_index_out(idx), .confirmed_read_index_out(bk), .udma_start_in(ev[2]),
        .udma_expected_done_in(ev[1]), .udma_end_in(ev[0]), .udma_word_valid_in(wvalid),
        .udma_word_ready_out(wready), .udma_word_in(wdata), .sector_word_valid_out(svalid),
        .sector_word_ready_in(sready), .sector_word_out(sdata),
        .udma_overrun_flag_out(flag), .extra_word_tally_out(tally), .udma_crc_out(crc));
    sfr_drive_model m (.clk_in(clk_in), .drain_in(drain), .word_valid_out(wvalid),
        .word_ready_in(wready), .word_out(wdata), .sector_valid_in(svalid),
        .sector_ready_out(sready), .sector_word_in(sdata));

    always #20 clk_in = ~clk_in;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [9:0] mask, input int n);
        ev = mask;
        repeat (n) step();
        ev = 10'h000;
        step();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_read = 1'b1;
        step();
        reg_read = 1'b0;
        step();
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic chk_idx();
        chk({2'b00, idx}, {2'b00, ci});
        chk({2'b00, bk}, {2'b00, cb});
    endtask
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_usb();
        fire(FETCH, 3);
        fire(ACK, 1);
        fire(FETCH, 2);
        ci = 14'h0005;
        cb = 14'h0003;
        chk_idx();
        fire(TMO, 1);
        ci = 14'h0003;
        chk_idx();
        fire(FETCH, 1);
        fire(RESEND, 1);
        chk_idx();
        rd(READ_INDEX_LOW_OFFSET, 8'h03);
        rd(CONFIRMED_READ_INDEX_LOW_OFFSET, 8'h03);
    endtask
    task automatic t_ata();
        fire(ATA | TMO, 1);
        ci = 14'h0004;
        cb = 14'h0004;
        chk_idx();
        fire(ATA, 300);
        ci = 14'h0130;
        cb = 14'h0130;
        chk_idx();
        rd(READ_INDEX_HIGH_OFFSET, 8'h01);
        rd(READ_INDEX_LOW_OFFSET, 8'h30);
        rd(CONFIRMED_READ_INDEX_HIGH_OFFSET, 8'h01);
        fire(FETCH | ACK, 1);
        ci = 14'h0131;
        cb = 14'h0131;
        chk_idx();
    endtask
    task automatic t_udma();
        int n;
        fire(LAUNCH, 1);
        fire(START, 1);
        ecrc = CRC_SEED;
        for (int i = 0; i < 32; i++) begin
            m.send(16'hA500 + 16'(i));
            ecrc = crc_step(ecrc, 16'hA500 + 16'(i));
        end
        m.release_bus();
        chk({15'h0000, wready}, 16'h0000);
        drain = 1'b1;
        n = 0;
        while (m.got.size() < 32 && n < 200) begin
            step();
            n++;
        end
        for (int i = 0; i < 32; i++) begin
            chk(m.got[i], 16'hA500 + 16'(i));
        end
        chk({15'h0000, svalid}, 16'h0000);
        fire(DONE, 1);
        for (int i = 0; i < 17; i++) begin
            m.send(16'h5A00 + 16'(i));
            ecrc = crc_step(ecrc, 16'h5A00 + 16'(i));
        end
        m.release_bus();
        step();
        chk({12'h000, tally}, 16'h000F);
        chk({15'h0000, flag}, 16'h0001);
        chk(16'(m.got.size()), 16'h0020);
        chk(crc, ecrc);
        rd(UDMA_EXTRA_WORD_TALLY_OFFSET, 8'h0F);
        fire(FINISH, 1);
        fire(LAUNCH, 1);
        chk({11'h000, flag, tally}, 16'h0000);
        fire(START, 1);
        fire(DONE, 1);
        m.send(16'h1234);
        m.send(16'h5678);
        m.release_bus();
        step();
        rd(UDMA_EXTRA_WORD_TALLY_OFFSET, 8'h02);
        fire(FINISH, 1);
        fire(SOFT, 1);
        rd(UDMA_EXTRA_WORD_TALLY_OFFSET, 8'h00);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #800000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        repeat (2) step();
        rd(CONFIRMED_READ_INDEX_HIGH_OFFSET, 8'h00);
        rd(UDMA_EXTRA_WORD_TALLY_OFFSET, 8'h00);
        rd(16'hF0F3, 8'h00);
        t_usb();
        t_ata();
        t_udma();
        close_out();
    end
endmodule // sfr_read_rewind_test
